// ### core/smm_pkg.sv
package smm_pkg;

  // Address map
  localparam logic [15:0] RAM_BASE = 16'h0050;
  localparam logic [15:0] RAM_LAST = 16'h024F;
  localparam logic [15:0] ZP_LAST = 16'h00FF;
  localparam logic [15:0] ROM_BASE = 16'hBE00;
  localparam logic [15:0] ROM_LAST = 16'hFDFF;
  localparam logic [15:0] VEC_BASE = 16'hFFD0;
  localparam logic [15:0] VEC_LAST = 16'hFFFF;
  localparam int RAM_BYTES = 512;
  localparam int ZP_RAM_BYTES = 176;
  localparam int ROM_BYTES = 16384;
  localparam int VEC_BYTES = 48;
  localparam int RAM_AW = 9;
  localparam int ROM_AW = 15;
  localparam logic [ROM_AW-1:0] VEC_ROM_OFS = 15'h4000;

  // Stack
  localparam logic [15:0] SP_RESET = 16'h00FF;
  localparam logic [2:0] IRQ_FRAME = 3'h5;
  localparam logic [2:0] CALL_FRAME = 3'h2;
  localparam logic [2:0] SLOT_PCL = 3'h0;
  localparam logic [2:0] SLOT_PCH = 3'h1;
  localparam logic [2:0] SLOT_XL = 3'h2;
  localparam logic [2:0] SLOT_ACC = 3'h3;
  localparam logic [2:0] SLOT_CCR = 3'h4;
  localparam logic [7:0] BLANK_BYTE = 8'h00;
  localparam int RD_LATENCY = 2;

  typedef enum logic [1:0] {REG_NONE, REG_RAM, REG_ROM, REG_VEC} smm_region_e;

  // Region of one 16-bit address
  function automatic smm_region_e smm_region_of(input logic [15:0] a);
    if (a >= RAM_BASE && a <= RAM_LAST)
      return REG_RAM;
    else if (a >= ROM_BASE && a <= ROM_LAST)
      return REG_ROM;
    else if (a >= VEC_BASE)
      return REG_VEC;
    return REG_NONE;
  endfunction : smm_region_of

  // Byte index inside the RAM array
  function automatic logic [RAM_AW-1:0] smm_ram_index(input logic [15:0] a);
    logic [15:0] d;
    d = a - RAM_BASE;
    return d[RAM_AW-1:0];
  endfunction : smm_ram_index

endpackage : smm_pkg

// ### core/smm_decode.sv
`timescale 1ns/1ps
module smm_decode (
  input wire logic [15:0] i_addr,
  output smm_pkg::smm_region_e o_region,
  output logic [smm_pkg::RAM_AW-1:0] o_ram_idx,
  output logic [smm_pkg::ROM_AW-1:0] o_rom_idx,
  output logic o_zero_page
);

  logic [15:0] rom_ofs;
  logic [15:0] vec_ofs;

  // Region and array offsets
  assign o_region = smm_pkg::smm_region_of(i_addr);
  assign o_ram_idx = smm_pkg::smm_ram_index(i_addr);
  assign rom_ofs = i_addr - smm_pkg::ROM_BASE;
  assign vec_ofs = i_addr - smm_pkg::VEC_BASE;
  assign o_rom_idx = (o_region == smm_pkg::REG_VEC) ?
    (smm_pkg::VEC_ROM_OFS | vec_ofs[smm_pkg::ROM_AW-1:0]) : rom_ofs[smm_pkg::ROM_AW-1:0];
  // Page zero RAM, reachable with an 8-bit address
  assign o_zero_page = (o_region == smm_pkg::REG_RAM) && (i_addr <= smm_pkg::ZP_LAST);

endmodule : smm_decode

// ### core/smm_ram.sv
`timescale 1ns/1ps
module smm_ram (
  input wire logic i_mclk,
  input wire logic i_we,
  input wire logic i_re,
  input wire logic [smm_pkg::RAM_AW-1:0] i_idx,
  input wire logic [7:0] i_wdata,
  output logic [7:0] o_rdata
);

  logic [7:0] mem [smm_pkg::RAM_BYTES];

  // Byte write
  always_ff @(posedge i_mclk)
  begin
    if (i_we)
      mem[i_idx] <= i_wdata;
  end

  // Registered read
  always_ff @(posedge i_mclk)
  begin
    if (i_re)
      o_rdata <= mem[i_idx];
  end

endmodule : smm_ram

// ### core/smm_stack_map.sv
`timescale 1ns/1ps
// How it works
// - 512 bytes of RAM answer at 0x0050 through 0x024F.
// - Stack pointer is 16 bits and may point anywhere.
// - Reset loads the stack pointer with 0x00FF; software may reload it.
// - 176 RAM bytes lie in page zero for direct addressing.
// - Interrupt entry pushes five bytes, one decrement per byte.
// - Index high byte is never part of the interrupt frame.
// - Call pushes two return bytes; return pulls them back.
// - Push decrements, pull increments; stack grows downward.
// - A 16384-byte read-only program region, apart from RAM.
// - Top 48 bytes up to 0xFFFF are read-only vectors.
// - Factory security option blanks external views of program contents.
module smm_stack_map (
  input wire logic i_mclk,
  input wire logic i_srst,
  input wire logic [15:0] i_addr,
  input wire logic i_rd,
  input wire logic i_wr,
  input wire logic [7:0] i_wdata,
  input wire logic [7:0] i_rom_rdata,
  input wire logic i_secure_opt,
  input wire logic i_ext_view,
  input wire logic i_sp_load,
  input wire logic [15:0] i_sp_value,
  input wire logic i_irq,
  input wire logic i_call,
  input wire logic i_rti,
  input wire logic i_ret,
  input wire logic [15:0] i_pc,
  input wire logic [7:0] i_x_lo,
  input wire logic [7:0] i_acc,
  input wire logic [7:0] i_ccr,
  output logic [7:0] o_rdata,
  output logic o_rd_valid,
  output logic [smm_pkg::ROM_AW-1:0] o_rom_addr,
  output logic o_rom_rd,
  output logic o_wr_refused,
  output logic o_zero_page,
  output logic [15:0] o_sp,
  output logic o_busy,
  output logic o_done,
  output logic o_stack_fault,
  output logic [15:0] o_pc,
  output logic [7:0] o_x_lo,
  output logic [7:0] o_acc,
  output logic [7:0] o_ccr
);

  typedef enum logic [1:0] {ST_IDLE, ST_PUSH, ST_PULL, ST_DRAIN} smm_state_e;

  smm_state_e state_q;
  smm_state_e state_d;
  logic [15:0] sp_q;
  logic [15:0] sp_inc;
  logic [2:0] cnt_q;
  logic [2:0] slot_q;
  logic [7:0] snap_q [5];
  logic sp_ok;
  logic pull_ok;
  logic idle;
  logic start_irq;
  logic start_call;
  logic start_rti;
  logic start_ret;
  logic bus_rd;
  logic bus_wr;
  smm_pkg::smm_region_e bus_region;
  logic [smm_pkg::RAM_AW-1:0] bus_ram_idx;
  logic [smm_pkg::ROM_AW-1:0] bus_rom_idx;
  logic bus_zp;
  logic ram_we;
  logic ram_re;
  logic [smm_pkg::RAM_AW-1:0] ram_idx;
  logic [7:0] ram_wdata;
  logic [7:0] ram_rdata;
  logic pend_q;
  logic pend_ok_q;
  logic [2:0] pend_slot_q;
  logic [7:0] pull_byte;
  logic secure_q;
  logic s1_valid_q;
  logic s1_blank_q;
  smm_pkg::smm_region_e s1_region_q;

  smm_decode u_dec (
    .i_addr(i_addr),
    .o_region(bus_region),
    .o_ram_idx(bus_ram_idx),
    .o_rom_idx(bus_rom_idx),
    .o_zero_page(bus_zp)
  );

  smm_ram u_ram (
    .i_mclk(i_mclk),
    .i_we(ram_we),
    .i_re(ram_re),
    .i_idx(ram_idx),
    .i_wdata(ram_wdata),
    .o_rdata(ram_rdata)
  );

  // Command decode, interrupt first
  assign idle = (state_q == ST_IDLE);
  assign start_irq = idle && i_irq;
  assign start_call = idle && !i_irq && i_call;
  assign start_rti = idle && !i_irq && !i_call && i_rti;
  assign start_ret = idle && !i_irq && !i_call && !i_rti && i_ret;
  assign bus_rd = idle && i_rd;
  assign bus_wr = idle && i_wr;
  assign sp_inc = sp_q + 16'h0001;
  assign sp_ok = (smm_pkg::smm_region_of(sp_q) == smm_pkg::REG_RAM);
  assign pull_ok = (smm_pkg::smm_region_of(sp_inc) == smm_pkg::REG_RAM);
  assign pull_byte = pend_ok_q ? ram_rdata : smm_pkg::BLANK_BYTE;

  // Sequencer next state
  always_comb
  begin
    state_d = state_q;
    case (state_q)
      ST_IDLE:
      begin
        if (start_irq || start_call)
          state_d = ST_PUSH;
        else if (start_rti || start_ret)
          state_d = ST_PULL;
      end
      ST_PUSH:
      begin
        if (cnt_q == 3'h1)
          state_d = ST_IDLE;
      end
      ST_PULL:
      begin
        if (cnt_q == 3'h1)
          state_d = ST_DRAIN;
      end
      default: state_d = ST_IDLE;
    endcase
  end

  // Sequencer state, busy and done
  always_ff @(posedge i_mclk)
  begin
    if (i_srst)
    begin
      state_q <= ST_IDLE;
      o_busy <= 1'b0;
      o_done <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      o_busy <= (state_d != ST_IDLE);
      o_done <= ((state_q == ST_PUSH) && (cnt_q == 3'h1)) || (state_q == ST_DRAIN);
    end
  end

  // Frame length and slot walk
  always_ff @(posedge i_mclk)
  begin
    if (i_srst)
    begin
      cnt_q <= 3'h0;
      slot_q <= 3'h0;
    end
    else if (start_irq)
    begin
      cnt_q <= smm_pkg::IRQ_FRAME;
      slot_q <= smm_pkg::SLOT_PCL;
    end
    else if (start_call)
    begin
      cnt_q <= smm_pkg::CALL_FRAME;
      slot_q <= smm_pkg::SLOT_PCL;
    end
    else if (start_rti)
    begin
      cnt_q <= smm_pkg::IRQ_FRAME;
      slot_q <= smm_pkg::SLOT_CCR;
    end
    else if (start_ret)
    begin
      cnt_q <= smm_pkg::CALL_FRAME;
      slot_q <= smm_pkg::SLOT_PCH;
    end
    else if (state_q == ST_PUSH)
    begin
      cnt_q <= cnt_q - 3'h1;
      slot_q <= slot_q + 3'h1;
    end
    else if (state_q == ST_PULL)
    begin
      cnt_q <= cnt_q - 3'h1;
      slot_q <= slot_q - 3'h1;
    end
  end

  // Frame snapshot; index high byte is left out
  always_ff @(posedge i_mclk)
  begin
    if (start_irq || start_call)
    begin
      snap_q[smm_pkg::SLOT_PCL] <= i_pc[7:0];
      snap_q[smm_pkg::SLOT_PCH] <= i_pc[15:8];
      snap_q[smm_pkg::SLOT_XL] <= i_x_lo;
      snap_q[smm_pkg::SLOT_ACC] <= i_acc;
      snap_q[smm_pkg::SLOT_CCR] <= i_ccr;
    end
  end

  // Stack pointer: full 16 bits
  always_ff @(posedge i_mclk)
  begin
    if (i_srst)
      sp_q <= smm_pkg::SP_RESET;
    else if (state_q == ST_PUSH)
      sp_q <= sp_q - 16'h0001;
    else if (state_q == ST_PULL)
      sp_q <= sp_inc;
    else if (idle && i_sp_load && !start_irq && !start_call && !start_rti && !start_ret)
      sp_q <= i_sp_value;
  end
  assign o_sp = sp_q;

  // RAM port: sequencer in frames, bus otherwise
  always_comb
  begin
    ram_we = 1'b0;
    ram_re = 1'b0;
    ram_idx = bus_ram_idx;
    ram_wdata = i_wdata;
    case (state_q)
      ST_PUSH:
      begin
        ram_idx = smm_pkg::smm_ram_index(sp_q);
        ram_wdata = snap_q[slot_q];
        ram_we = sp_ok;
      end
      ST_PULL:
      begin
        ram_idx = smm_pkg::smm_ram_index(sp_inc);
        ram_re = pull_ok;
      end
      ST_IDLE:
      begin
        ram_we = bus_wr && (bus_region == smm_pkg::REG_RAM);
        ram_re = bus_rd && (bus_region == smm_pkg::REG_RAM);
      end
      default: ram_re = 1'b0;
    endcase
  end

  // Stack access outside RAM, sticky until reset
  always_ff @(posedge i_mclk)
  begin
    if (i_srst)
      o_stack_fault <= 1'b0;
    else if (((state_q == ST_PUSH) && !sp_ok) || ((state_q == ST_PULL) && !pull_ok))
      o_stack_fault <= 1'b1;
  end

  // Pulled byte tracking
  always_ff @(posedge i_mclk)
  begin
    if (i_srst)
    begin
      pend_q <= 1'b0;
      pend_ok_q <= 1'b0;
      pend_slot_q <= 3'h0;
    end
    else
    begin
      pend_q <= (state_q == ST_PULL);
      pend_ok_q <= pull_ok;
      pend_slot_q <= slot_q;
    end
  end

  // Restore registers in reverse order
  always_ff @(posedge i_mclk)
  begin
    if (i_srst)
    begin
      o_pc <= 16'h0000;
      o_x_lo <= 8'h00;
      o_acc <= 8'h00;
      o_ccr <= 8'h00;
    end
    else if (pend_q)
    begin
      case (pend_slot_q)
        smm_pkg::SLOT_PCL: o_pc[7:0] <= pull_byte;
        smm_pkg::SLOT_PCH: o_pc[15:8] <= pull_byte;
        smm_pkg::SLOT_XL: o_x_lo <= pull_byte;
        smm_pkg::SLOT_ACC: o_acc <= pull_byte;
        default: o_ccr <= pull_byte;
      endcase
    end
  end

  // Security option sampled while reset is held
  always_ff @(posedge i_mclk)
  begin
    if (i_srst)
      secure_q <= i_secure_opt;
  end

  // Bus stage 1: program fetch address, refusal of writes
  always_ff @(posedge i_mclk)
  begin
    if (i_srst)
    begin
      o_rom_addr <= '0;
      o_rom_rd <= 1'b0;
      o_wr_refused <= 1'b0;
      o_zero_page <= 1'b0;
      s1_valid_q <= 1'b0;
      s1_blank_q <= 1'b0;
      s1_region_q <= smm_pkg::REG_NONE;
    end
    else
    begin
      o_rom_addr <= bus_rom_idx;
      o_rom_rd <= bus_rd && ((bus_region == smm_pkg::REG_ROM) || (bus_region == smm_pkg::REG_VEC));
      o_wr_refused <= bus_wr && (bus_region != smm_pkg::REG_RAM);
      o_zero_page <= (bus_rd || bus_wr) && bus_zp;
      s1_valid_q <= bus_rd;
      s1_blank_q <= secure_q && i_ext_view;
      s1_region_q <= bus_region;
    end
  end

  // Bus stage 2: read data
  always_ff @(posedge i_mclk)
  begin
    if (i_srst)
    begin
      o_rd_valid <= 1'b0;
      o_rdata <= 8'h00;
    end
    else
    begin
      o_rd_valid <= s1_valid_q;
      if (s1_valid_q)
      begin
        case (s1_region_q)
          smm_pkg::REG_RAM: o_rdata <= ram_rdata;
          smm_pkg::REG_ROM, smm_pkg::REG_VEC: o_rdata <= s1_blank_q ? smm_pkg::BLANK_BYTE : i_rom_rdata;
          default: o_rdata <= smm_pkg::BLANK_BYTE;
        endcase
      end
    end
  end

  // Checks
  default clocking cb @(posedge i_mclk);
  endclocking

  sequence push_run5;
    (state_q == ST_PUSH) [*5] ##1 (o_done && idle);
  endsequence

  chk_sp_reset_value: assert property ($past(i_srst) |-> o_sp == smm_pkg::SP_RESET)
    else $error("stack pointer not at reset value");
  chk_irq_five_push: assert property (disable iff (i_srst) start_irq |=> push_run5)
    else $error("interrupt frame not five pushes");
  chk_irq_sp_drop: assert property (disable iff (i_srst)
    start_irq |=> ##5 (o_sp == 16'($past(o_sp, 6) - 16'h0005)))
    else $error("stack pointer not lowered by five");
  chk_push_byte_order: assert property (disable iff (i_srst)
    start_irq |=> (ram_wdata == $past(i_pc[7:0])) ##1 (ram_wdata == $past(i_pc[15:8], 2))
    ##1 (ram_wdata == $past(i_x_lo, 3)) ##1 (ram_wdata == $past(i_acc, 4)) ##1 (ram_wdata == $past(i_ccr, 5)))
    else $error("interrupt frame order wrong");
  chk_call_two_push: assert property (disable iff (i_srst)
    start_call |=> (state_q == ST_PUSH) [*2] ##1 (o_done && idle && o_sp == 16'($past(o_sp, 3) - 16'h0002)))
    else $error("call frame not two pushes");
  chk_ret_two_pull: assert property (disable iff (i_srst)
    start_ret |=> (state_q == ST_PULL) [*2] ##1 (state_q == ST_DRAIN)
    ##1 (o_done && o_sp == 16'($past(o_sp, 4) + 16'h0002)))
    else $error("return not two pulls");
  chk_rti_slot_walk: assert property (disable iff (i_srst)
    start_rti |=> (slot_q == 3'h4) ##1 (slot_q == 3'h3) ##1 (slot_q == 3'h2) ##1 (slot_q == 3'h1) ##1 (slot_q == 3'h0))
    else $error("restore order wrong");
  chk_ram_write_map: assert property (disable iff (i_srst)
    (bus_wr && i_addr >= 16'h0050 && i_addr <= 16'h024F) |-> (ram_we && ram_idx == 9'(i_addr - 16'h0050)))
    else $error("RAM write not decoded");
  chk_rom_refuse: assert property (disable iff (i_srst)
    (bus_wr && i_addr >= 16'hBE00) |-> (!ram_we ##1 o_wr_refused))
    else $error("read-only write not refused");
  chk_secure_blank: assert property (disable iff (i_srst)
    (bus_rd && i_addr >= 16'hFFD0 && secure_q && i_ext_view) |=> ##1 (o_rd_valid && o_rdata == 8'h00))
    else $error("secure read not blanked");

endmodule : smm_stack_map

// ### tb/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  logic i_mclk, i_srst, i_rd, i_wr, i_secure_opt, i_ext_view, i_sp_load, i_irq, i_call, i_rti, i_ret;
  logic [15:0] i_addr, i_sp_value, i_pc, o_sp, o_pc;
  logic [7:0] i_wdata, i_rom_rdata, i_x_lo, i_acc, i_ccr, o_rdata, o_x_lo, o_acc, o_ccr;
  logic [smm_pkg::ROM_AW-1:0] o_rom_addr;
  logic o_rd_valid, o_rom_rd, o_wr_refused, o_zero_page, o_busy, o_done, o_stack_fault;
  logic [15:0] a, pc;
  logic [7:0] d, x, ac, cc;
  int num_errors, total_checks, cycles;
  logic [15:0] edge_addr [9] = '{16'h0050, 16'h00FF, 16'h0100, 16'h024F, 16'h004F, 16'h0250, 16'h0000,
                                 16'hBE00, 16'hFFFF};

  smm_stack_map uut (.i_mclk, .i_srst, .i_addr, .i_rd, .i_wr, .i_wdata, .i_rom_rdata, .i_secure_opt,
    .i_ext_view, .i_sp_load, .i_sp_value, .i_irq, .i_call, .i_rti, .i_ret, .i_pc, .i_x_lo, .i_acc, .i_ccr,
    .o_rdata, .o_rd_valid, .o_rom_addr, .o_rom_rd, .o_wr_refused, .o_zero_page, .o_sp, .o_busy, .o_done,
    .o_stack_fault, .o_pc, .o_x_lo, .o_acc, .o_ccr);

  // Clock at 50 MHz
  initial
  begin
    i_mclk = 1'b0;
    forever #10 i_mclk = ~i_mclk;
  end

  // Hang guard
  always @(posedge i_mclk)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      num_errors++;
      stop_test();
    end
  end

  // Address classes worked out from the map
  function automatic logic in_ram(input logic [15:0] v);
    return v >= smm_pkg::RAM_BASE && v <= smm_pkg::RAM_LAST;
  endfunction : in_ram

  function automatic logic is_rom(input logic [15:0] v);
    return (v >= smm_pkg::ROM_BASE && v <= smm_pkg::ROM_LAST) || v >= smm_pkg::VEC_BASE;
  endfunction : is_rom

  function automatic logic [14:0] rom_idx(input logic [15:0] v);
    logic [15:0] r;
    r = (v >= smm_pkg::VEC_BASE) ? (v - smm_pkg::VEC_BASE + 16'h4000) : (v - smm_pkg::ROM_BASE);
    return r[14:0];
  endfunction : rom_idx

  task automatic stop_test();
    if (num_errors == 0 && total_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : stop_test

  task automatic chk_val(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      num_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_val

  task automatic chk_bit(input logic got, input logic exp);
    total_checks++;
    if (got !== exp)
    begin
      num_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_bit

  // One edge, then settle past it
  task automatic step();
    @(posedge i_mclk);
    #1;
  endtask : step

  // Bus read with fixed two-cycle answer
  task automatic bus_read(input logic [15:0] ad, input logic ext, input logic [7:0] rom, input logic [7:0] exp);
    i_addr = ad;
    i_rd = 1'b1;
    i_ext_view = ext;
    i_rom_rdata = rom;
    step();
    i_rd = 1'b0;
    chk_bit(o_zero_page, in_ram(ad) && ad <= smm_pkg::ZP_LAST);
    chk_bit(o_rom_rd, is_rom(ad));
    if (is_rom(ad))
      chk_val(16'(o_rom_addr), 16'(rom_idx(ad)));
    chk_bit(o_rd_valid, 1'b0);
    step();
    chk_bit(o_rd_valid, 1'b1);
    chk_val(16'(o_rdata), 16'(exp));
  endtask : bus_read

  // Bus write; refused outside RAM
  task automatic bus_write(input logic [15:0] ad, input logic [7:0] dat);
    i_addr = ad;
    i_wdata = dat;
    i_wr = 1'b1;
    step();
    i_wr = 1'b0;
    chk_bit(o_wr_refused, !in_ram(ad));
    step();
  endtask : bus_write

  // Stack command, counting edges until done
  task automatic run_cmd(input int k, input int lat);
    int n;
    case (k)
      0: i_irq = 1'b1;
      1: i_call = 1'b1;
      2: i_rti = 1'b1;
      default: i_ret = 1'b1;
    endcase
    step();
    {i_irq, i_call, i_rti, i_ret} = 4'h0;
    chk_bit(o_busy, 1'b1);
    n = 1;
    while (o_done !== 1'b1 && n < 20)
    begin
      step();
      n++;
    end
    chk_val(16'(n), 16'(lat));
  endtask : run_cmd

  task automatic sp_load(input logic [15:0] v);
    i_sp_value = v;
    i_sp_load = 1'b1;
    step();
    i_sp_load = 1'b0;
    chk_val(o_sp, v);
  endtask : sp_load

  initial
  begin
    {i_rd, i_wr, i_secure_opt, i_ext_view, i_sp_load, i_irq, i_call, i_rti, i_ret} = 9'h000;
    {i_addr, i_sp_value, i_pc, i_wdata, i_rom_rdata, i_x_lo, i_acc, i_ccr} = 80'h0;
    i_srst = 1'b1;
    void'($urandom(32'hd33abe6b));
    repeat (3) step();
    i_srst = 1'b0;
    chk_val(o_sp, 16'h00FF);
    chk_bit(o_stack_fault, 1'b0);
    // Map edges: RAM ends, page-zero edge, gaps and program space
    foreach (edge_addr[i])
    begin
      d = 8'($urandom);
      bus_write(edge_addr[i], d);
      bus_read(edge_addr[i], 1'b0, ~d, in_ram(edge_addr[i]) ? d : (is_rom(edge_addr[i]) ? ~d : 8'h00));
    end
    // Random RAM traffic
    repeat (40)
    begin
      a = smm_pkg::RAM_BASE + 16'($urandom % 512);
      d = 8'($urandom);
      bus_write(a, d);
      bus_read(a, 1'($urandom), 8'($urandom), d);
    end
    // Random program and vector reads
    repeat (30)
    begin
      a = ($urandom % 3 == 0) ? smm_pkg::VEC_BASE + 16'($urandom % 48) : smm_pkg::ROM_BASE + 16'($urandom % 16384);
      d = 8'($urandom);
      bus_read(a, 1'($urandom), d, d);
    end
    // Interrupt frame and its return
    pc = 16'($urandom);
    {x, ac, cc} = 24'($urandom);
    {i_pc, i_x_lo, i_acc, i_ccr} = {pc, x, ac, cc};
    bus_write(16'h00FA, 8'h5A);
    run_cmd(0, 6);
    chk_val(o_sp, 16'h00FA);
    bus_read(16'h00FF, 1'b0, 8'h00, pc[7:0]);
    bus_read(16'h00FE, 1'b0, 8'h00, pc[15:8]);
    bus_read(16'h00FD, 1'b0, 8'h00, x);
    bus_read(16'h00FC, 1'b0, 8'h00, ac);
    bus_read(16'h00FB, 1'b0, 8'h00, cc);
    bus_read(16'h00FA, 1'b0, 8'h00, 8'h5A);
    {i_pc, i_x_lo, i_acc, i_ccr} = 40'h0;
    run_cmd(2, 7);
    chk_val(o_sp, 16'h00FF);
    chk_val(o_pc, pc);
    chk_val({o_x_lo, o_acc}, {x, ac});
    chk_val(16'(o_ccr), 16'(cc));
    // Relocated stack, call and return
    sp_load(16'h0200);
    pc = 16'($urandom);
    i_pc = pc;
    run_cmd(1, 3);
    chk_val(o_sp, 16'h01FE);
    bus_read(16'h0200, 1'b0, 8'h00, pc[7:0]);
    bus_read(16'h01FF, 1'b0, 8'h00, pc[15:8]);
    i_pc = 16'h0000;
    run_cmd(3, 4);
    chk_val(o_sp, 16'h0200);
    chk_val(o_pc, pc);
    // Stack pointer reaches the full space
    sp_load(16'hF000);
    run_cmd(1, 3);
    chk_bit(o_stack_fault, 1'b1);
    // Secured part: external views blanked
    i_secure_opt = 1'b1;
    i_srst = 1'b1;
    repeat (2) step();
    i_srst = 1'b0;
    i_secure_opt = 1'b0;
    chk_val(o_sp, 16'h00FF);
    chk_bit(o_stack_fault, 1'b0);
    bus_read(16'hBE10, 1'b1, 8'hA5, 8'h00);
    bus_read(16'hBE10, 1'b0, 8'hA5, 8'hA5);
    bus_read(16'hFFFE, 1'b1, 8'h3C, 8'h00);
    stop_test();
  end
endmodule : tb_top
